// ---- hw/fro_pkg.sv ----
package fro_pkg;
	// register map
	localparam logic [31:0] OPT_WORD_ADDR = 32'hFFFFFF88;
	localparam logic [31:0] CTRL_ADDR = 32'h00080036;
	localparam logic [31:0] WAIT_ADDR = 32'h000800A5;
	localparam logic [31:0] CLK3_ADDR = 32'h00080026;
	localparam logic [31:0] FLAG_ADDR = 32'h0008003C;
	localparam logic [31:0] IRQ_ST_ADDR = 32'h00080040;
	localparam logic [31:0] IRQ_MSK_ADDR = 32'h00080041;

	// field positions
	localparam int VDSEL_LSB = 0;
	localparam int VOLTAGE_DETECT_RESET_START_BIT = 2;
	localparam int EN_BIT = 8;
	localparam int STOP_BIT = 0;
	localparam int CKSEL_LSB = 8;
	localparam int STABLE_BIT = 3;

	// voltage detection level codes
	localparam logic [1:0] LVL_3V84 = 2'h0;
	localparam logic [1:0] LVL_2V51 = 2'h2;

	typedef enum logic [2:0]
	{
		SRC_LOW = 3'h0,
		SRC_FAST = 3'h1,
		SRC_MAIN = 3'h2,
		SRC_PLL = 3'h4
	} fro_src_t;

	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int EV_STABLE = 0;
	localparam int EV_STOPPED = 1;
	localparam int EV_BADSEL = 2;

	// reset values
	localparam logic [7:0] WAIT_RST = 8'h00;
	localparam logic [2:0] CKSEL_RST = 3'h0;
	localparam logic [IRQ_W-1:0] MSK_RST = 3'h0;

	// timing
	localparam int CLK_MHZ = 250;
	localparam int FAST_OSC_MHZ = 32;
	localparam int STOP_NS = 20;
	localparam int STOP_CYC = (STOP_NS * CLK_MHZ + 999) / 1000;
	localparam int WAIT_STEP_CYC = 16;
	localparam int CNT_W = 16;
endpackage

// ---- hw/fro_osc_if.sv ----
`timescale 1ns/1ps
interface fro_osc_if;
	import fro_pkg::*;
	logic stop_req;
	logic [CNT_W-1:0] settle_cyc;
	logic running;
	logic stable;
	logic ev_stable;
	logic ev_stopped;

	modport ctl (output stop_req, output settle_cyc, input running, input stable,
		input ev_stable, input ev_stopped);
	modport osc (input stop_req, input settle_cyc, output running, output stable,
		output ev_stable, output ev_stopped);
endinterface

// ---- hw/fro_opt_latch.sv ----
`timescale 1ns/1ps
module fro_opt_latch import fro_pkg::*;
#(
	parameter int W = 32
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// option storage
	input wire logic [W-1:0] nv_word,
	output logic [W-1:0] word
);
	logic [W-1:0] sync1;
	logic [W-1:0] sync2;

	always_ff @(posedge clk)
	begin
		sync1 <= nv_word;
		sync2 <= sync1;
	end

	// captured only while reset is held; frozen afterwards
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			word <= sync2;
	end
endmodule // fro_opt_latch

// ---- hw/fro_osc_ctl.sv ----
`timescale 1ns/1ps
module fro_osc_ctl import fro_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	fro_osc_if.osc o
);
	typedef enum logic [1:0] {OSC_OFF, OSC_SETTLE, OSC_ON, OSC_STOPPING} fro_osc_t;
	fro_osc_t state;
	fro_osc_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			OSC_OFF:
				if (!o.stop_req)
				begin
					next_state = OSC_SETTLE;
					next_cnt = o.settle_cyc;
				end
			OSC_SETTLE:
				if (o.stop_req)
				begin
					next_state = OSC_STOPPING;
					next_cnt = CNT_W'(STOP_CYC);
				end
				else if (cnt <= 16'h0001)
					next_state = OSC_ON;
				else
					next_cnt = cnt - 16'h0001;
			OSC_ON:
				if (o.stop_req)
				begin
					next_state = OSC_STOPPING;
					next_cnt = CNT_W'(STOP_CYC);
				end
			OSC_STOPPING:
				// a restart waits until the stop has completed
				if (cnt <= 16'h0001)
					next_state = OSC_OFF;
				else
					next_cnt = cnt - 16'h0001;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= OSC_OFF;
			cnt <= '0;
			o.ev_stable <= 1'b0;
			o.ev_stopped <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			o.ev_stable <= state == OSC_SETTLE && next_state == OSC_ON;
			o.ev_stopped <= state == OSC_STOPPING && next_state == OSC_OFF;
		end
	end

	assign o.running = state != OSC_OFF;
	assign o.stable = state == OSC_ON;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	stable_set_a: assert property ($rose(o.stable) |-> $past(state == OSC_SETTLE && !o.stop_req))
		else $error("stable flag set without settling");
	stable_clr_a: assert property (o.stable && o.stop_req |=> !o.stable ##5 !o.running)
		else $error("stop did not clear flag or stop oscillator");
endmodule // fro_osc_ctl

// ---- hw/fro_top.sv ----
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - option word readable at its fixed address
// - level field 00 3.84 V, 10 2.51 V
// - bit 2 zero enables voltage monitor reset
// - reserved option bits read programmed value
// - bit 8 zero runs fast oscillator
// - oscillator starts before the CPU runs
// - option never changes clock source select
// - only CPU write changes clock source
// - CPU reset held until oscillator settles when bit 8 is zero, released at once when it is one
// - fast oscillator nominal 32 MHz
// - 1-bit control register (stop bit 0) at its address
// - 8-bit wait control register at its address
// - source codes low, fast, main, PLL
// - stable flag bit 3 reflects oscillator
// - flag sets after start, clears after stop
module fro_top import fro_pkg::*;
#(
	parameter int SETTLE_NS = 50000
)
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// option storage
	input wire logic [31:0] opt_nv_word,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// clock generator
	output logic [2:0] sys_clk_sel,
	output logic fast_osc_run,
	output logic cpu_rst_hold,
	// voltage detector
	output logic [1:0] voltage_detect_level_select,
	output logic voltage_detect_level_bad,
	output logic voltage_detect_reset_start_en,
	// interrupt
	output logic irq
);
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

	fro_osc_if osc_bus ();

	logic [31:0] opt_word;
	logic stop_bit;
	logic stop_wr;
	logic ctrl_written;
	logic [7:0] wait_ctl;
	logic [2:0] cksel;
	logic [IRQ_W-1:0] irq_st;
	logic [IRQ_W-1:0] irq_msk;

	wire hit_opt;
	wire hit_ctrl;
	wire hit_wait;
	wire hit_clk3;
	wire hit_flag;
	wire hit_st;
	wire hit_msk;
	wire opt_osc_en;
	wire cksel_ok;
	wire bad_sel_ev;
	wire rd_st;
	wire next_hold;
	wire [2:0] wr_sel;
	wire [1:0] opt_lvl;
	wire [IRQ_W-1:0] ev_vec;
	wire [IRQ_W-1:0] next_irq_st;
	wire [31:0] rd_mux;

	fro_opt_latch #(.W(32)) u_opt
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.nv_word(opt_nv_word),
		.word(opt_word)
	);

	fro_osc_ctl u_osc
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.o(osc_bus.osc)
	);

	// address decode
	assign hit_opt = reg_addr == OPT_WORD_ADDR;
	assign hit_ctrl = reg_addr == CTRL_ADDR;
	assign hit_wait = reg_addr == WAIT_ADDR;
	assign hit_clk3 = reg_addr == CLK3_ADDR;
	assign hit_flag = reg_addr == FLAG_ADDR;
	assign hit_st = reg_addr == IRQ_ST_ADDR;
	assign hit_msk = reg_addr == IRQ_MSK_ADDR;

	// option fields; zero in bit 8 means run after reset
	assign opt_osc_en = !opt_word[EN_BIT];
	assign opt_lvl = opt_word[VDSEL_LSB +: 2];

	// clock source select
	assign wr_sel = reg_wdata[CKSEL_LSB +: 3];
	assign cksel_ok = wr_sel inside {SRC_LOW, SRC_FAST, SRC_MAIN, SRC_PLL};
	assign bad_sel_ev = reg_wr && hit_clk3 && !cksel_ok;

	// oscillator hookup; the wait register lengthens the settle count
	assign osc_bus.stop_req = stop_bit;
	assign osc_bus.settle_cyc = CNT_W'(SETTLE_CYC) + {4'h0, wait_ctl, 4'h0};

	// hold is one-shot: a later stop never re-holds the CPU
	assign next_hold = cpu_rst_hold && opt_osc_en && !osc_bus.stable;

	// interrupt status: an event in the clearing cycle survives
	assign rd_st = reg_rd && hit_st;
	assign ev_vec = {bad_sel_ev, osc_bus.ev_stopped, osc_bus.ev_stable};
	assign next_irq_st = (irq_st & ~{IRQ_W{rd_st}}) | ev_vec;

	assign rd_mux = hit_opt ? opt_word :
		hit_ctrl ? {31'h0, stop_bit} :
		hit_wait ? {24'h0, wait_ctl} :
		hit_clk3 ? {21'h0, cksel, 8'h00} :
		hit_flag ? {28'h0, osc_bus.stable, 3'h0} :
		hit_st ? {29'h0, irq_st} :
		hit_msk ? {29'h0, irq_msk} :
		32'h0;

	// follows the frozen option word until software writes control
	assign stop_bit = ctrl_written ? stop_wr : opt_word[EN_BIT];

	// a registered copy would lag the option capture by one edge
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stop_wr <= 1'b1;
			ctrl_written <= 1'b0;
		end
		else if (reg_wr && hit_ctrl)
		begin
			stop_wr <= reg_wdata[STOP_BIT];
			ctrl_written <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wait_ctl <= WAIT_RST;
		else if (reg_wr && hit_wait)
			wait_ctl <= reg_wdata[7:0];
	end

	// prohibited codes are dropped so the mux never sees them
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cksel <= CKSEL_RST;
		else if (reg_wr && hit_clk3 && cksel_ok)
			cksel <= wr_sel;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			irq_msk <= MSK_RST;
		else if (reg_wr && hit_msk)
			irq_msk <= reg_wdata[IRQ_W-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			irq_st <= '0;
		else
			irq_st <= next_irq_st;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cpu_rst_hold <= 1'b1;
		else
			cpu_rst_hold <= next_hold;
	end

	// nominal 32 MHz source; run marks it delivered to the generator
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fast_osc_run <= 1'b0;
			sys_clk_sel <= CKSEL_RST;
			irq <= 1'b0;
		end
		else
		begin
			fast_osc_run <= osc_bus.running;
			sys_clk_sel <= cksel;
			irq <= |(next_irq_st & irq_msk);
		end
	end

	// detector controls follow the frozen option word
	always_ff @(posedge clk)
	begin
		voltage_detect_level_select <= opt_lvl;
		voltage_detect_level_bad <= opt_lvl != LVL_3V84 && opt_lvl != LVL_2V51;
		voltage_detect_reset_start_en <= !opt_word[VOLTAGE_DETECT_RESET_START_BIT];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	opt_read_a: assert property (reg_rd && hit_opt |=> reg_rdata == $past(opt_word))
		else $error("option word read mismatch");
	lvl_code_a: assert property (voltage_detect_level_bad |->
		voltage_detect_level_select inside {2'h1, 2'h3})
		else $error("level flagged bad for a legal code");
	lvd_start_a: assert property (reg_rd && hit_opt ##1 voltage_detect_reset_start_en |->
		!reg_rdata[VOLTAGE_DETECT_RESET_START_BIT])
		else $error("monitor reset enable disagrees with option");
	rsv_bits_a: assert property (reg_rd && hit_opt |=>
		reg_rdata[31:9] == $past(opt_word[31:9]) && reg_rdata[7:3] == $past(opt_word[7:3]))
		else $error("reserved option bits altered");
	boot_run_a: assert property ($fell(sys_rst) && opt_osc_en |-> ##[1:3] fast_osc_run)
		else $error("fast oscillator not started after reset");
	no_run_a: assert property ($fell(sys_rst) && !opt_osc_en |-> !fast_osc_run [*3])
		else $error("fast oscillator ran while disabled by option");
	sel_hold_a: assert property (!(reg_wr && hit_clk3) ##1 1'b1 |=> $stable(sys_clk_sel))
		else $error("clock source changed without a write");
	sel_write_a: assert property (reg_wr && hit_clk3 && cksel_ok |->
		##2 sys_clk_sel == $past(wr_sel, 2))
		else $error("clock source write not applied");
	sel_legal_a: assert property (sys_clk_sel inside {SRC_LOW, SRC_FAST, SRC_MAIN, SRC_PLL})
		else $error("prohibited clock source selected");
	hold_rel_a: assert property ($fell(cpu_rst_hold) |-> !opt_osc_en || $past(osc_bus.stable))
		else $error("CPU released before oscillator settled");
	ctrl_wr_a: assert property (reg_wr && hit_ctrl |=> stop_bit == $past(reg_wdata[STOP_BIT]))
		else $error("control register write lost");
	wait_rd_a: assert property (reg_wr && hit_wait ##1 reg_rd && hit_wait |=>
		reg_rdata == {24'h0, $past(reg_wdata[7:0], 2)})
		else $error("wait control readback wrong");
	flag_rd_a: assert property (reg_rd && hit_flag |=>
		reg_rdata[STABLE_BIT] == $past(osc_bus.stable))
		else $error("stable flag readback wrong");
	opt_frozen_a: assert property (!$past(sys_rst) |-> $stable(opt_word))
		else $error("option word changed outside reset");
	irq_keep_a: assert property (rd_st && |ev_vec |=> |(irq_st & $past(ev_vec)))
		else $error("event lost in clearing cycle");

	// release from reset and option-driven outputs
	sel_boot_a: assert property ($fell(sys_rst) |-> sys_clk_sel == CKSEL_RST)
		else $error("clock source not at reset value after release");
	hold_off_a: assert property (!opt_osc_en |=> !cpu_rst_hold)
		else $error("CPU held although the oscillator is disabled");
	hold_run_a: assert property ($fell(cpu_rst_hold) && opt_osc_en |->
		fast_osc_run)
		else $error("CPU released before the oscillator ran");
	lvl_follow_a: assert property (!$past(sys_rst) |->
		voltage_detect_level_select == opt_lvl)
		else $error("level select does not follow the option word");
	run_on_a: assert property (osc_bus.stable |=> fast_osc_run)
		else $error("stable oscillator not reported running");
	stop_flag_a: assert property (stop_bit |=> !osc_bus.stable)
		else $error("stable flag set while stop requested");

	// register side effects
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data present without a read");
	ctrl_rd_a: assert property (reg_rd && hit_ctrl |=>
		reg_rdata == {31'h0, $past(stop_bit)})
		else $error("control readback wrong");
	wait_keep_a: assert property (!(reg_wr && hit_wait) |=> $stable(wait_ctl))
		else $error("wait control changed without a write");
	bad_sel_st_a: assert property (bad_sel_ev |=> irq_st[EV_BADSEL])
		else $error("prohibited select write not reported");
	sel_drop_a: assert property (bad_sel_ev |=> $stable(cksel))
		else $error("prohibited select code was taken");
	msk_wr_a: assert property (reg_wr && hit_msk |=>
		irq_msk == $past(reg_wdata[IRQ_W-1:0]))
		else $error("mask write lost");
	st_clr_a: assert property (rd_st && !(|ev_vec) |=> irq_st == {IRQ_W{1'b0}})
		else $error("status not cleared by read");
	irq_lvl_a: assert property ($stable(irq_msk) |-> irq == |(irq_st & irq_msk))
		else $error("interrupt disagrees with status and mask");

	// main scenarios
	boot_c: cover property ($fell(sys_rst) && opt_osc_en ##[1:1000] $fell(cpu_rst_hold));
	hold_off_c: cover property ($fell(sys_rst) && !opt_osc_en);
	fast_sel_c: cover property (reg_wr && hit_clk3 && wr_sel == SRC_FAST);
	stop_c: cover property (osc_bus.ev_stopped);
	irq_c: cover property ($rose(irq));
endmodule // fro_top

// ---- verification/fro_top_tb.sv ----
`timescale 1ns/1ps
module fro_top_tb import fro_pkg::*;;
	localparam logic [31:0] OPT_ON = 32'hFFFFFEFA;
	localparam logic [31:0] OPT_OFF = 32'hFFFFFFFD;
	logic clk;
	logic sys_rst;
	logic [31:0] opt_nv_word;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [2:0] sys_clk_sel;
	logic fast_osc_run;
	logic cpu_rst_hold;
	logic [1:0] lvl_sel;
	logic lvl_bad;
	logic lvl_rst_en;
	logic irq;
	logic [31:0] rd_val;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	logic [2:0] codes [4] = '{SRC_LOW, SRC_FAST, SRC_MAIN, SRC_PLL};

	// short settle so the run stays small: 10 cycles
	fro_top #(.SETTLE_NS(40)) dut
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.opt_nv_word(opt_nv_word),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.sys_clk_sel(sys_clk_sel),
		.fast_osc_run(fast_osc_run),
		.cpu_rst_hold(cpu_rst_hold),
		.voltage_detect_level_select(lvl_sel),
		.voltage_detect_level_bad(lvl_bad),
		.voltage_detect_reset_start_en(lvl_rst_en),
		.irq(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares = miscompares + 1;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// write then read with no gap between the strobes
	task automatic wr_rd(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// bounded wait: for irq high, or for the cpu hold to drop
	task automatic wait_for(input bit on_irq, input int limit);
		int n;
		n = 0;
		while ((on_irq ? irq !== 1'b1 : cpu_rst_hold !== 1'b0) && n < limit)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	initial
	begin
		sys_rst = 1'b1;
		opt_nv_word = OPT_ON;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("hold", {31'h0, cpu_rst_hold}, 32'h1);
		wait_for(0, 40);
		chk("run", {31'h0, fast_osc_run}, 32'h1);
		chk("src", {29'h0, sys_clk_sel}, 32'h0);
		chk("lvl", {30'h0, lvl_sel}, 32'h2);
		chk("bad", {31'h0, lvl_bad}, 32'h0);
		chk("lvrst", {31'h0, lvl_rst_en}, 32'h1);
		rd(FLAG_ADDR);
		chk("flag", rd_val, 32'h8);
		rd(CTRL_ADDR);
		chk("ctrl", rd_val, 32'h0);
		rd(WAIT_ADDR);
		chk("wait", rd_val, 32'h0);
		wr(OPT_WORD_ADDR, 32'h0);
		opt_nv_word <= 32'h0;
		rd(OPT_WORD_ADDR);
		chk("opt", rd_val, OPT_ON);
		rd(32'h00080037);
		chk("unmapped", rd_val, 32'h0);
		rd(IRQ_ST_ADDR);
		chk("st", rd_val, 32'h1);
		$display("test startup done");

		wr_rd(IRQ_MSK_ADDR, 32'h7);
		chk("msk", rd_val, 32'h7);
		foreach (codes[i])
		begin
			wr(CLK3_ADDR, {21'h0, codes[i], 8'h00});
			rd(CLK3_ADDR);
			chk("sel reg", rd_val, {21'h0, codes[i], 8'h00});
			chk("sel out", {29'h0, sys_clk_sel}, {29'h0, codes[i]});
		end
		wr(CLK3_ADDR, 32'h300);
		rd(CLK3_ADDR);
		chk("bad sel", rd_val, 32'h400);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(IRQ_ST_ADDR);
		chk("st", rd_val, 32'h4);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("test clock select done");

		wr(CTRL_ADDR, 32'h1);
		rd(FLAG_ADDR);
		chk("flag", rd_val, 32'h0);
		// status read lands on the stop-complete edge: the event must survive
		repeat (3) @(posedge clk);
		rd(IRQ_ST_ADDR);
		chk("st", rd_val, 32'h0);
		chk("run", {31'h0, fast_osc_run}, 32'h0);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(IRQ_ST_ADDR);
		chk("st", rd_val, 32'h2);
		chk("irq", {31'h0, irq}, 32'h0);
		wr_rd(WAIT_ADDR, 32'h101);
		chk("wait", rd_val, 32'h1);
		// restart now needs 10 + 16 cycles
		wr(CTRL_ADDR, 32'h0);
		repeat (15) @(posedge clk);
		rd(FLAG_ADDR);
		chk("early", rd_val, 32'h0);
		wait_for(1, 60);
		rd(FLAG_ADDR);
		chk("flag", rd_val, 32'h8);
		rd(IRQ_ST_ADDR);
		chk("st", rd_val, 32'h1);
		$display("test stop restart done");

		@(posedge clk);
		opt_nv_word <= OPT_OFF;
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("hold", {31'h0, cpu_rst_hold}, 32'h0);
		@(posedge clk);
		#1;
		chk("hold", {31'h0, cpu_rst_hold}, 32'h0);
		chk("run", {31'h0, fast_osc_run}, 32'h0);
		chk("src", {29'h0, sys_clk_sel}, 32'h0);
		chk("lvl", {30'h0, lvl_sel}, 32'h1);
		chk("bad", {31'h0, lvl_bad}, 32'h1);
		chk("lvrst", {31'h0, lvl_rst_en}, 32'h0);
		rd(FLAG_ADDR);
		chk("flag", rd_val, 32'h0);
		rd(CTRL_ADDR);
		chk("ctrl", rd_val, 32'h1);
		rd(OPT_WORD_ADDR);
		chk("opt", rd_val, OPT_OFF);
		$display("test disabled done");
		stop_test();
	end
endmodule // fro_top_tb
